// file: ddq_bus_dev.sv
// Fieldbus device model
`timescale 1ns/10ps
`default_nettype none
module ddq_bus_dev (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   // Bench control
   input wire logic send_i,
   input wire ddq_pkg::ddq_dgram_t send_dg_i,
   input wire logic [7:0] delay_i,
   // Bus
   input wire logic tx_valid_i,
   input wire ddq_pkg::ddq_dgram_t tx_dg_i,
   input wire logic tx_auto_i,
   output logic rx_valid_o,
   output ddq_pkg::ddq_dgram_t rx_dg_o
);
   logic [7:0] cnt_q;
   ddq_pkg::ddq_dgram_t rpl_q;
   wire fire = cnt_q == 8'h01;
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cnt_q <= 8'h00;
         rpl_q <= '0;
         rx_valid_o <= 1'b0;
         rx_dg_o <= '0;
      end else begin
         rx_valid_o <= send_i || fire;
         rx_dg_o <= send_i ? send_dg_i : fire ? rpl_q : ~rx_dg_o;
         if (tx_valid_i && !tx_auto_i && delay_i != 8'h00) begin
            cnt_q <= delay_i;
            rpl_q <= {tx_dg_i.dev, tx_dg_i.fc + 8'h01, tx_dg_i.len};
         end else if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
         end
      end
   end
endmodule : ddq_bus_dev
`default_nettype wire

// file: ddq_dispatch.sv
// Datagram dispatch, automatic handling and host request execution
// What this block does
// - Only the send and send-with-reply requests put a datagram on the bus.
// - The send request takes any function code, reply-type codes included.
// - A reply to a datagram sent by the plain send request is queued, except test complete after a pulse test sent that way.
// - An incoming identification read is answered by the block itself, or dropped if a send or reply request is taken in the same cycle.
// - Incoming device reads and diagnostics reads are answered automatically, or dropped if a send or reply request is taken in the same cycle.
// - Reply codes are consumed and returned only for a pending reply request.
// - Listed unsolicited codes are queued until the host dequeues them.
// - An incoming fault report is written to the fault table.
// - Test complete is consumed when the pulse test went by plain send.
// - Request 8 enables or disables cyclic outputs per device or for all.
// - Every request ends with a two-word status, general and detailed.
// - Each dequeue of a non-empty queue moves one datagram, truncated with a data error if long.
`timescale 1ns/10ps
`default_nettype none
module ddq_dispatch #(
   parameter int QDEPTH = 8
) (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   // Host request port
   input wire logic req_valid_i,
   input wire ddq_pkg::ddq_req_t req_i,
   output logic done_o,
   output ddq_pkg::ddq_status_t status_o,
   output ddq_pkg::ddq_dgram_t host_dg_o,
   output logic host_dg_valid_o,
   output logic [7:0] host_dg_len_o,
   // Bus receive side
   input wire logic rx_valid_i,
   input wire ddq_pkg::ddq_dgram_t rx_dg_i,
   // Bus transmit side
   output logic tx_valid_o,
   output ddq_pkg::ddq_dgram_t tx_dg_o,
   output logic tx_auto_o,
   // Fault table write
   output logic fault_we_o,
   output logic [7:0] fault_dev_o,
   // Cyclic output enables
   output logic [ddq_pkg::DEV_COUNT-1:0] out_en_o
);
   typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_BUSY = 2'b01} ddq_state_t;

   ddq_state_t state_q;
   logic wait_rpl_q;
   logic [7:0] wait_fc_q;
   logic pulse_q;
   ddq_pkg::ddq_dgram_t head;
   logic q_empty;
   logic q_full;

   // Host request decode
   wire take = req_valid_i && (state_q == ST_IDLE);
   wire is_send = take && (req_i.cmd == ddq_pkg::REQ_SEND);
   wire is_reply = take && (req_i.cmd == ddq_pkg::REQ_REPLY);
   wire is_deq = take && (req_i.cmd == ddq_pkg::REQ_DEQUEUE);
   wire is_out = take && (req_i.cmd == ddq_pkg::REQ_OUTPUTS);
   wire dev_bad = (req_i.dg.dev >= 8'(ddq_pkg::DEV_COUNT))
      && (req_i.dg.dev != ddq_pkg::DEV_ALL);
   wire bad_cmd = take && !is_send && !is_reply && !is_deq && !is_out;

   // Incoming classification
   wire rx_fc_id = rx_dg_i.fc == ddq_pkg::FC_READ_ID;
   wire rx_fc_dev = rx_dg_i.fc == ddq_pkg::FC_READ_DEV;
   wire rx_fc_diag = rx_dg_i.fc == ddq_pkg::FC_READ_DIAG;
   wire rx_auto_rd = rx_valid_i && (rx_fc_id || rx_fc_dev || rx_fc_diag);
   wire rx_is_rpl = (rx_dg_i.fc == ddq_pkg::FC_READ_ID_RPL)
      || (rx_dg_i.fc == ddq_pkg::FC_READ_CFG_RPL)
      || (rx_dg_i.fc == ddq_pkg::FC_READ_DIAG_RPL)
      || (rx_dg_i.fc == ddq_pkg::FC_READ_IO_RPL)
      || (rx_dg_i.fc == ddq_pkg::FC_READ_DEV_RPL)
      || (rx_dg_i.fc == ddq_pkg::FC_READ_DATA_RPL)
      || (rx_dg_i.fc == ddq_pkg::FC_MAP_RPL);
   wire rpl_match = rx_valid_i && rx_is_rpl && wait_rpl_q
      && (rx_dg_i.fc == wait_fc_q + 8'h01);
   wire rx_queue_fc = (rx_dg_i.fc == ddq_pkg::FC_READ_CFG)
      || (rx_dg_i.fc == ddq_pkg::FC_ASSIGN_MON)
      || (rx_dg_i.fc == ddq_pkg::FC_WRITE_POINT)
      || (rx_dg_i.fc == ddq_pkg::FC_PULSE)
      || (rx_dg_i.fc == ddq_pkg::FC_CLR_ALL)
      || (rx_dg_i.fc == ddq_pkg::FC_READ_DATA)
      || (rx_dg_i.fc == ddq_pkg::FC_WRITE_DATA)
      || (rx_dg_i.fc == ddq_pkg::FC_WRITE_MAP);
   wire rx_fault = rx_valid_i && (rx_dg_i.fc == ddq_pkg::FC_FAULT);
   wire rx_pdone = rx_valid_i && pulse_q
      && (rx_dg_i.fc == ddq_pkg::FC_PULSE_DONE);
   // Unmatched replies and unknown codes queue for the host
   wire rx_push = rx_valid_i && !rx_auto_rd && !rpl_match && !rx_fault
      && !rx_pdone && (rx_queue_fc || rx_is_rpl || 1'b1);

   // Dequeue result
   wire deq_pop = is_deq && !q_empty;
   wire deq_long = head.len > req_i.max_len;
   wire [7:0] deq_len = deq_long ? req_i.max_len : head.len;

   // Transmit select: host send, reply request, or automatic answer
   wire host_tx = is_send || is_reply;
   ddq_pkg::ddq_dgram_t auto_dg;
   assign auto_dg.dev = rx_dg_i.dev;
   assign auto_dg.fc = rx_dg_i.fc + 8'h01;
   assign auto_dg.len = '0;

   ddq_queue #(.DEPTH(QDEPTH)) u_queue (
      .core_clk_i(core_clk_i),
      .rst_b_i(rst_b_i),
      .push_i(rx_push),
      .push_dg_i(rx_dg_i),
      .pop_i(deq_pop),
      .head_o(head),
      .empty_o(q_empty),
      .full_o(q_full)
   );

   // Request state: busy until a pending reply arrives
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_q <= ST_IDLE;
         wait_rpl_q <= 1'b0;
         wait_fc_q <= '0;
      end else if (is_reply) begin
         state_q <= ST_BUSY;
         wait_rpl_q <= 1'b1;
         wait_fc_q <= req_i.dg.fc;
      end else if (rpl_match) begin
         state_q <= ST_IDLE;
         wait_rpl_q <= 1'b0;
      end
   end

   // Pulse test sent by plain send arms test-complete consumption
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pulse_q <= 1'b0;
      end else if (is_send && req_i.dg.fc == ddq_pkg::FC_PULSE) begin
         pulse_q <= 1'b1;
      end else if (rx_pdone) begin
         pulse_q <= 1'b0;
      end
   end

   // Cyclic output enables
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         out_en_o <= ddq_pkg::OUT_EN_RST;
      end else if (is_out && req_i.dg.dev == ddq_pkg::DEV_ALL) begin
         out_en_o <= {ddq_pkg::DEV_COUNT{req_i.en}};
      end else if (is_out && !dev_bad) begin
         out_en_o[req_i.dg.dev[4:0]] <= req_i.en;
      end
   end

   // Completion status and host data
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         done_o <= 1'b0;
         status_o <= '0;
         host_dg_o <= '0;
         host_dg_valid_o <= 1'b0;
         host_dg_len_o <= '0;
      end else begin
         done_o <= (take && !is_reply) || rpl_match;
         host_dg_valid_o <= deq_pop || rpl_match;
         if (rpl_match) begin
            status_o <= {ddq_pkg::XS_NONE, ddq_pkg::ST_OK};
            host_dg_o <= rx_dg_i;
            host_dg_len_o <= rx_dg_i.len;
         end else if (is_deq && q_empty) begin
            status_o <= {ddq_pkg::XS_NONE, ddq_pkg::ST_NO_DATA};
         end else if (deq_pop) begin
            host_dg_o <= head;
            host_dg_len_o <= deq_len;
            status_o <= deq_long
               ? {ddq_pkg::XS_PARTIAL, ddq_pkg::ST_DATA_ERR}
               : {ddq_pkg::XS_NONE, ddq_pkg::ST_OK};
         end else if (is_out && dev_bad) begin
            status_o <= {ddq_pkg::XS_BAD_DEV, ddq_pkg::ST_SYNTAX};
         end else if (bad_cmd) begin
            status_o <= {ddq_pkg::XS_BAD_CMD, ddq_pkg::ST_SYNTAX};
         end else if (take && !is_reply) begin
            status_o <= {ddq_pkg::XS_NONE, ddq_pkg::ST_OK};
         end
      end
   end

   // Bus transmit and fault table
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         tx_valid_o <= 1'b0;
         tx_dg_o <= '0;
         tx_auto_o <= 1'b0;
         fault_we_o <= 1'b0;
         fault_dev_o <= '0;
      end else begin
         tx_valid_o <= host_tx || rx_auto_rd;
         tx_auto_o <= !host_tx && rx_auto_rd;
         if (host_tx) begin
            tx_dg_o <= req_i.dg;
         end else if (rx_auto_rd) begin
            tx_dg_o <= auto_dg;
         end
         fault_we_o <= rx_fault;
         fault_dev_o <= rx_dg_i.dev;
      end
   end
endmodule : ddq_dispatch
`default_nettype wire

// file: ddq_dispatch_asserts.sv
// Port assertions of the dispatch block
`timescale 1ns/10ps
`default_nettype none
module ddq_dispatch_asserts (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   // Host side
   input wire logic req_valid_i,
   input wire ddq_pkg::ddq_req_t req_i,
   input wire logic done_o,
   input wire ddq_pkg::ddq_status_t status_o,
   // Bus side
   input wire logic rx_valid_i,
   input wire ddq_pkg::ddq_dgram_t rx_dg_i,
   input wire logic tx_valid_o,
   input wire ddq_pkg::ddq_dgram_t tx_dg_o,
   input wire logic tx_auto_o,
   input wire logic fault_we_o,
   input wire logic [7:0] fault_dev_o,
   input wire logic [ddq_pkg::DEV_COUNT-1:0] out_en_o
);
   logic busy_q;
   logic [7:0] exp_q;
   wire take = req_valid_i && !busy_q;
   wire [7:0] cmd = req_i.cmd;
   wire [7:0] fc = rx_dg_i.fc;
   wire rpl = rx_valid_i && busy_q && fc == exp_q
      && (fc inside {8'h01, 8'h03, 8'h09, 8'h0d, 8'h1f, 8'h28, 8'h2b});
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         busy_q <= 1'b0;
         exp_q <= 8'h00;
      end else if (take && cmd == 8'h0f) begin
         busy_q <= 1'b1;
         exp_q <= req_i.dg.fc + 8'h01;
      end else if (rpl) begin
         busy_q <= 1'b0;
      end
   end
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_b_i);
   sequence s_take(c);
      take && cmd == c;
   endsequence
   AST_SEND: assert property (s_take(8'h0e) |=> tx_valid_o && done_o
      && tx_dg_o == $past(req_i.dg) && status_o == 32'h0000_0004)
      else $error("Send failed");
   AST_REPLY_TX: assert property (s_take(8'h0f) |=> tx_valid_o && !done_o
      && tx_dg_o == $past(req_i.dg)) else $error("Reply request not sent");
   AST_REPLY_DONE: assert property (rpl |=> done_o
      && status_o[15:0] == 16'h0004) else $error("Reply not returned");
   AST_AUTO_ID: assert property (rx_valid_i && fc == 8'h00
      && !req_valid_i |=> tx_valid_o && tx_auto_o && tx_dg_o.fc == 8'h01)
      else $error("Id read not answered");
   AST_AUTO_RD: assert property (rx_valid_i && fc inside {8'h08, 8'h1e}
      && !req_valid_i |=> tx_auto_o && tx_dg_o.fc == $past(fc) + 8'h01)
      else $error("Read not answered");
   AST_FAULT: assert property (rx_valid_i && fc == 8'h0f |=> fault_we_o
      && fault_dev_o == $past(rx_dg_i.dev)) else $error("Fault not logged");
   AST_OUT_ALL: assert property (take && cmd == 8'h08
      && req_i.dg.dev == 8'hff |=> out_en_o == {32{$past(req_i.en)}})
      else $error("Outputs not set");
   AST_BAD_CMD: assert property (take
      && !(cmd inside {8'h08, [8'h0d:8'h0f]}) |=> done_o
      && !(tx_valid_o && !tx_auto_o) && status_o == 32'h00ce_0008)
      else $error("Bad request taken");
endmodule : ddq_dispatch_asserts
`default_nettype wire

// file: ddq_pkg.sv
// Package of constants and types for the datagram dispatch block
package ddq_pkg;
   // Host request numbers
   localparam logic [7:0] REQ_OUTPUTS = 8'h08;
   localparam logic [7:0] REQ_DEQUEUE = 8'h0d;
   localparam logic [7:0] REQ_SEND = 8'h0e;
   localparam logic [7:0] REQ_REPLY = 8'h0f;
   // Datagram function codes
   localparam logic [7:0] FC_READ_ID = 8'h00;
   localparam logic [7:0] FC_READ_ID_RPL = 8'h01;
   localparam logic [7:0] FC_READ_CFG = 8'h02;
   localparam logic [7:0] FC_READ_CFG_RPL = 8'h03;
   localparam logic [7:0] FC_ASSIGN_MON = 8'h05;
   localparam logic [7:0] FC_READ_DIAG = 8'h08;
   localparam logic [7:0] FC_READ_DIAG_RPL = 8'h09;
   localparam logic [7:0] FC_WRITE_POINT = 8'h0b;
   localparam logic [7:0] FC_READ_IO_RPL = 8'h0d;
   localparam logic [7:0] FC_FAULT = 8'h0f;
   localparam logic [7:0] FC_PULSE = 8'h10;
   localparam logic [7:0] FC_PULSE_DONE = 8'h11;
   localparam logic [7:0] FC_CLR_ALL = 8'h13;
   localparam logic [7:0] FC_READ_DEV = 8'h1e;
   localparam logic [7:0] FC_READ_DEV_RPL = 8'h1f;
   localparam logic [7:0] FC_READ_DATA = 8'h27;
   localparam logic [7:0] FC_READ_DATA_RPL = 8'h28;
   localparam logic [7:0] FC_WRITE_DATA = 8'h29;
   localparam logic [7:0] FC_MAP_RPL = 8'h2b;
   localparam logic [7:0] FC_WRITE_MAP = 8'h2c;
   // Lower status word codes
   localparam logic [15:0] ST_OK = 16'h0004;
   localparam logic [15:0] ST_SYNTAX = 16'h0008;
   localparam logic [15:0] ST_DATA_ERR = 16'h0010;
   localparam logic [15:0] ST_NO_DATA = 16'h0040;
   // Upper status word codes
   localparam logic [15:0] XS_NONE = 16'h0000;
   localparam logic [15:0] XS_PARTIAL = 16'h00d0;
   localparam logic [15:0] XS_BAD_CMD = 16'h00ce;
   localparam logic [15:0] XS_BAD_DEV = 16'h00c9;
   // Device numbers
   localparam logic [7:0] DEV_ALL = 8'hff;
   localparam int DEV_COUNT = 32;
   // Reset value of the enable of cyclic outputs
   localparam logic [31:0] OUT_EN_RST = 32'hffff_ffff;

   // One datagram header
   typedef struct packed {
      logic [7:0] dev;
      logic [7:0] fc;
      logic [7:0] len;
   } ddq_dgram_t;

   // Host request
   typedef struct packed {
      logic [7:0] cmd;
      ddq_dgram_t dg;
      logic [7:0] max_len;
      logic en;
   } ddq_req_t;

   // Two-word completion status
   typedef struct packed {
      logic [15:0] upper;
      logic [15:0] lower;
   } ddq_status_t;
endpackage : ddq_pkg

// file: ddq_queue.sv
// In-order queue of unsolicited incoming datagrams
`timescale 1ns/10ps
`default_nettype none
module ddq_queue #(
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   // Fill side
   input wire logic push_i,
   input wire ddq_pkg::ddq_dgram_t push_dg_i,
   // Drain side
   input wire logic pop_i,
   output ddq_pkg::ddq_dgram_t head_o,
   output logic empty_o,
   output logic full_o
);
   localparam int AW = $clog2(DEPTH);
   ddq_pkg::ddq_dgram_t mem_q [DEPTH];
   logic [AW:0] wr_q;
   logic [AW:0] rd_q;
   wire do_push = push_i && !full_o;
   wire do_pop = pop_i && !empty_o;

   assign empty_o = (wr_q == rd_q);
   assign full_o = (wr_q[AW-1:0] == rd_q[AW-1:0]) && (wr_q[AW] != rd_q[AW]);
   assign head_o = mem_q[rd_q[AW-1:0]];

   always_ff @(posedge core_clk_i) begin
      if (do_push) begin
         mem_q[wr_q[AW-1:0]] <= push_dg_i;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         if (do_push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (do_pop) begin
            rd_q <= rd_q + 1'b1;
         end
      end
   end
endmodule : ddq_queue
`default_nettype wire

// file: tb_top.sv
// Self-checking bench of the dispatch block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic core_clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic req_valid_i = 1'b0;
   logic send = 1'b0;
   // Queue depth given to the design
   localparam int QDEPTH = 8;
   logic done_o, host_dg_valid_o, rx_valid_i, tx_valid_o, tx_auto_o;
   logic fault_we_o;
   logic [7:0] host_dg_len_o, fault_dev_o, dly = 8'h00;
   logic [31:0] seed = 32'hd1f69b31, r, es;
   logic [ddq_pkg::DEV_COUNT-1:0] out_en_o, ee = ddq_pkg::OUT_EN_RST;
   ddq_pkg::ddq_req_t req_i = '0;
   ddq_pkg::ddq_status_t status_o;
   ddq_pkg::ddq_dgram_t host_dg_o, rx_dg_i, tx_dg_o, sdg = '0, d, q[$];
   logic [7:0] cd[19] = '{8'h02, 8'h05, 8'h0b, 8'h10, 8'h13, 8'h27, 8'h29,
      8'h2c, 8'h01, 8'h11, 8'h00, 8'h08, 8'h1e, 8'h0f, 8'h00, 8'h13, 8'h10,
      8'h27, 8'h1e};
   int bad_count = 0, checks = 0, i, j;
   bit pulse = 1'b0;
   always #5 core_clk_i = ~core_clk_i;
   ddq_dispatch #(.QDEPTH(QDEPTH)) i_dut (.core_clk_i, .rst_b_i, .req_valid_i,
      .req_i, .done_o,
      .status_o, .host_dg_o, .host_dg_valid_o, .host_dg_len_o, .rx_valid_i,
      .rx_dg_i, .tx_valid_o, .tx_dg_o, .tx_auto_o, .fault_we_o, .fault_dev_o,
      .out_en_o);
   ddq_bus_dev i_dev (.core_clk_i, .rst_b_i, .send_i(send), .send_dg_i(sdg),
      .delay_i(dly), .tx_valid_i(tx_valid_o), .tx_dg_i(tx_dg_o),
      .tx_auto_i(tx_auto_o), .rx_valid_o(rx_valid_i), .rx_dg_o(rx_dg_i));
   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   task chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task stop_test();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : stop_test
   task rx(input logic [7:0] fc);
      r = rnd();
      d = {r[7:0], fc, r[15:8]};
      @(posedge core_clk_i);
      send <= 1'b1;
      sdg <= d;
      @(posedge core_clk_i);
      send <= 1'b0;
      if (!(fc inside {8'h00, 8'h08, 8'h0f, 8'h1e}) && !(fc == 8'h11 && pulse))
         if (q.size() < QDEPTH) q.push_back(d);
      repeat (3) @(posedge core_clk_i);
   endtask : rx
   // Enable bit rides on low bit of max length
   task req(input logic [7:0] cmd, fc, dev, ml);
      r = rnd();
      @(posedge core_clk_i);
      req_valid_i <= 1'b1;
      req_i <= {cmd, dev, fc, r[7:0], ml, ml[0]};
      @(posedge core_clk_i);
      req_valid_i <= 1'b0;
      #1;
      for (i = 0; i < 30 && done_o !== 1'b1; i++) begin
         @(posedge core_clk_i);
         #1;
      end
      if (done_o !== 1'b1) begin
         bad_count++;
         stop_test();
      end
      es = 32'h0000_0004;
      if (cmd == 8'h0e) begin
         pulse |= fc == 8'h10;
         if (dly != 8'h00 && fc != 8'h10 && q.size() < QDEPTH)
            q.push_back({dev, fc + 8'h01, r[7:0]});
      end else if (cmd == 8'h0f) begin
         chk(host_dg_o.fc, fc + 8'h01, "reply code");
      end else if (cmd == 8'h0d) begin
         if (q.size() == 0) es = 32'h0000_0040;
         else begin
            d = q.pop_front();
            if (d.len > ml) es = 32'h00d0_0010;
            chk(host_dg_valid_o, 1'b1, "valid");
            chk(host_dg_o[23:8], d[23:8], "head");
            chk(host_dg_len_o, d.len > ml ? ml : d.len, "length");
         end
      end else if (cmd == 8'h08) begin
         if (dev == 8'hff) ee = {32{ml[0]}};
         else if (dev < 8'h20) ee[dev[4:0]] = ml[0];
         else es = 32'h00c9_0008;
         chk(out_en_o, ee, "outputs");
      end else es = 32'h00ce_0008;
      chk(status_o, es, "status");
      if (cmd == 8'h0e) repeat (dly + 8'h04) @(posedge core_clk_i);
   endtask : req
   initial begin
      repeat (3) @(posedge core_clk_i);
      chk(out_en_o, ee, "reset enables");
      rst_b_i <= 1'b1;
      for (j = 0; j < 14; j++) rx(cd[j]);
      for (j = 0; j < 11; j++) req(8'h0d, 8'h00, 8'h00, 8'(rnd() & 32'h3f));
      $display("test incoming done");
      dly = 8'h03;
      for (j = 14; j < 17; j++) req(8'h0e, cd[j], r[7:0], 8'hff);
      for (j = 0; j < 3; j++) req(8'h0d, 8'h00, 8'h00, 8'hff);
      $display("test send done");
      for (j = 0; j < 4; j++) begin
         dly = j[0] ? 8'h06 : 8'h01;
         req(8'h0f, cd[17 + j[1]], r[7:0], 8'hff);
      end
      $display("test reply done");
      dly = 8'h00;
      req(8'h08, 8'h00, 8'hff, 8'h00);
      req(8'h08, 8'h00, 8'h05, 8'h01);
      req(8'h08, 8'h00, 8'h28, 8'h01);
      req(8'h07, 8'h00, 8'h00, 8'h00);
      $display("test requests done");
      stop_test();
   end
endmodule : tb_top
bind ddq_dispatch ddq_dispatch_asserts i_chk (.core_clk_i, .rst_b_i,
   .req_valid_i, .req_i, .done_o, .status_o, .rx_valid_i, .rx_dg_i,
   .tx_valid_o, .tx_dg_o, .tx_auto_o, .fault_we_o, .fault_dev_o, .out_en_o);
`default_nettype wire
